/* File: core/burst_cfg_pkg.sv */
// Configuration layout, codes and carriers for the burst read sequencer.
// Assumes a single 20 MHz system clock domain inside the device.
package burst_cfg_pkg;

    // ****************************************************************
    // Configuration word layout
    // ****************************************************************
    typedef struct packed {
        logic       read_sync_select;
        logic       reserved_hi;
        logic [2:0] first_access_latency;
        logic       wait_polarity_sel;
        logic       data_hold_sel;
        logic       wait_timing_sel;
        logic       burst_order_sel;
        logic       active_edge_sel;
        logic       reserved_mid_a;
        logic       reserved_mid_b;
        logic       wrap_disable;
        logic [2:0] burst_len_sel;
    } cfg_t;

    localparam int   CFG_W     = 16;
    localparam cfg_t CFG_RESET = 16'hFFCF;

    // ****************************************************************
    // Field codes
    // ****************************************************************
    localparam logic [2:0] LEN_4    = 3'h1;
    localparam logic [2:0] LEN_8    = 3'h2;
    localparam logic [2:0] LEN_16   = 3'h3;
    localparam logic [4:0] WORDS_4  = 5'h04;
    localparam logic [4:0] WORDS_8  = 5'h08;
    localparam logic [4:0] WORDS_16 = 5'h10;
    localparam logic [4:0] WORDS_CONT = 5'h00;
    localparam logic [2:0] LAT_MIN  = 3'h2;
    localparam logic [2:0] LAT_MAX  = 3'h7;

    // ****************************************************************
    // Synchronised control pins
    // ****************************************************************
    typedef struct packed {
        logic burst_clk;
        logic latch_n;
        logic chip_en_n;
        logic out_en_n;
    } pins_t;

    localparam pins_t PINS_IDLE = 4'h7;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LAT,
        ST_DATA,
        ST_WAIT,
        ST_DONE
    } burst_state_t;

endpackage

/* File: core/burst_read_config_sequencer.sv */
// Burst read configuration register and burst address sequencer.
// Assumes the array answers one request at a time on the clk domain,
// and that all pins are asynchronous to clk and much slower than it.
`timescale 1ns/1ps
module burst_read_config_sequencer
    import burst_cfg_pkg::*;
#(
    parameter int ADDR_W = 23,
    parameter int DATA_W = 16,
    parameter int DEPTH  = 2
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              burst_clk,
    input  wire logic              latch_n,
    input  wire logic              chip_en_n,
    input  wire logic              out_en_n,
    input  wire logic [ADDR_W-1:0] addr_pin,
    input  wire logic              cfg_load,
    input  wire cfg_t              cfg_value,
    output cfg_t                   cfg_readback,
    output logic                   array_req_valid,
    input  wire logic              array_req_ready,
    output logic [ADDR_W-1:0]      array_req_addr,
    input  wire logic              array_rsp_valid,
    output logic                   array_rsp_ready,
    input  wire logic [DATA_W-1:0] array_rsp_data,
    output logic [DATA_W-1:0]      dq_out,
    output logic                   dq_oe,
    output logic                   wait_out,
    output logic                   wait_oe,
    output logic                   burst_active
);

    localparam int SW = 4 + ADDR_W;
    localparam int PW = $clog2(DEPTH);
    localparam logic [SW-1:0] SYNC_RST = {PINS_IDLE, {ADDR_W{1'b0}}};

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [4:0] len_words(input logic [2:0] code);
        case (code)
            LEN_4:   len_words = WORDS_4;
            LEN_8:   len_words = WORDS_8;
            LEN_16:  len_words = WORDS_16;
            default: len_words = WORDS_CONT;
        endcase
    endfunction

    function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
                                                    input logic [4:0] len,
                                                    input logic wrap);
        logic [ADDR_W-1:0] m;
        m = {{(ADDR_W-5){1'b0}}, len - 5'h01};
        if (!wrap || len == WORDS_CONT)
            next_addr = a + 1'b1;
        else
            next_addr = (a & ~m) | ((a + 1'b1) & m);
    endfunction

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [SW-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
    logic          k_last_reg, sel_last_reg;
    pins_t         pin;
    logic [ADDR_W-1:0] addr_in;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_reg   <= SYNC_RST;
            s2_reg   <= SYNC_RST;
            s3_reg   <= SYNC_RST;
            filt_reg <= SYNC_RST;
        end else begin
            s1_reg   <= {burst_clk, latch_n, chip_en_n, out_en_n, addr_pin};
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            filt_reg <= (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & filt_reg);
        end
    end

    assign pin     = filt_reg[SW-1 -: 4];
    assign addr_in = filt_reg[ADDR_W-1:0];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            k_last_reg   <= 1'b0;
            sel_last_reg <= 1'b1;
        end else begin
            k_last_reg   <= pin.burst_clk;
            sel_last_reg <= pin.latch_n | pin.chip_en_n;
        end
    end

    // ****************************************************************
    // Configuration register
    // ****************************************************************
    cfg_t cfg_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            cfg_reg <= CFG_RESET;
        else if (cfg_load)
            cfg_reg <= cfg_value;
    end

    assign cfg_readback = cfg_reg;

    logic       sync_mode, act_edge, cont, wrap_eff, sel, ce_on, hold2;
    logic [2:0] lat_val;
    logic [4:0] words;

    assign sync_mode = !cfg_reg.read_sync_select;
    assign act_edge  = cfg_reg.active_edge_sel ? (pin.burst_clk & ~k_last_reg)
                                               : (~pin.burst_clk & k_last_reg);
    assign lat_val   = (cfg_reg.first_access_latency < LAT_MIN) ? LAT_MAX
                                                                : cfg_reg.first_access_latency;
    assign words     = len_words(cfg_reg.burst_len_sel);
    assign cont      = (words == WORDS_CONT);
    assign wrap_eff  = !cfg_reg.wrap_disable && !cont;
    assign hold2     = cfg_reg.data_hold_sel;
    assign sel       = pin.latch_n | pin.chip_en_n;
    assign ce_on     = !pin.chip_en_n;

    // ****************************************************************
    // Burst sequencing
    // ****************************************************************
    burst_state_t      state_reg;
    logic              armed_reg, waited_reg, misalign_reg, hold_cnt_reg, pend_reg;
    logic [2:0]        lat_cnt_reg;
    logic [4:0]        words_left_reg, fetch_left_reg;
    logic [ADDR_W-1:0] out_addr_reg, fetch_addr_reg;
    logic [PW:0]       buf_cnt_reg;
    logic              start, abort, step, begin_cyc, need_ws;
    logic              go_done, go_ws, pop, stall, push;

    assign start = act_edge && armed_reg && !sel && sync_mode && !pend_reg;
    assign abort = !ce_on && state_reg != ST_IDLE;
    assign step  = act_edge && state_reg != ST_IDLE;

    always_comb begin
        begin_cyc = 1'b0;
        if (step && state_reg == ST_LAT)
            begin_cyc = (lat_cnt_reg == 3'h1);
        else if (step && (state_reg == ST_DATA || state_reg == ST_WAIT))
            begin_cyc = !hold_cnt_reg;
    end

    assign need_ws = misalign_reg && !waited_reg && !wrap_eff && (out_addr_reg[3:0] == 4'h0);
    assign go_done = begin_cyc && !cont && words_left_reg == 5'h00;
    assign go_ws   = begin_cyc && !go_done && need_ws;
    assign pop     = begin_cyc && !go_done && !go_ws && buf_cnt_reg != '0;
    assign stall   = begin_cyc && !go_done && !go_ws && buf_cnt_reg == '0;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            armed_reg <= 1'b0;
        else if (sel_last_reg && !sel)
            armed_reg <= 1'b1;
        else if (start || sel)
            armed_reg <= 1'b0;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            state_reg <= ST_IDLE;
        else if (start)
            state_reg <= ST_LAT;
        else if (abort)
            state_reg <= ST_IDLE;
        else if (go_done)
            state_reg <= ST_DONE;
        else if (go_ws || stall)
            state_reg <= ST_WAIT;
        else if (pop)
            state_reg <= ST_DATA;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            lat_cnt_reg <= 3'h0;
        else if (start)
            lat_cnt_reg <= lat_val;
        else if (step && state_reg == ST_LAT && lat_cnt_reg != 3'h0)
            lat_cnt_reg <= lat_cnt_reg - 3'h1;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            hold_cnt_reg <= 1'b0;
        else if (pop || go_ws)
            hold_cnt_reg <= hold2;
        else if (step && hold_cnt_reg)
            hold_cnt_reg <= 1'b0;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            waited_reg   <= 1'b0;
            misalign_reg <= 1'b0;
        end else if (start) begin
            waited_reg   <= 1'b0;
            misalign_reg <= (addr_in[2:0] != 3'h0);
        end else if (go_ws) begin
            waited_reg   <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_addr_reg   <= '0;
            words_left_reg <= 5'h00;
        end else if (start) begin
            out_addr_reg   <= addr_in;
            words_left_reg <= words;
        end else if (pop) begin
            out_addr_reg   <= next_addr(out_addr_reg, words, wrap_eff);
            words_left_reg <= cont ? words_left_reg : words_left_reg - 5'h01;
        end
    end

    // ****************************************************************
    // Array fetch and two-entry buffer
    // ****************************************************************
    // Fetch runs ahead of the pins; buffer depth bounds the lookahead.
    logic [DATA_W-1:0] mem [DEPTH];
    logic [PW-1:0]     wr_ptr_reg, rd_ptr_reg;

    assign array_req_valid = state_reg != ST_IDLE && !pend_reg && !abort
                             && buf_cnt_reg < DEPTH && (cont || fetch_left_reg != 5'h00);
    assign array_req_addr  = fetch_addr_reg;
    assign array_rsp_ready = buf_cnt_reg < DEPTH;
    // Stale answers after an abort are accepted and dropped
    assign push            = array_rsp_valid && array_rsp_ready && pend_reg && state_reg != ST_IDLE;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fetch_addr_reg <= '0;
            fetch_left_reg <= 5'h00;
        end else if (start) begin
            fetch_addr_reg <= addr_in;
            fetch_left_reg <= words;
        end else if (array_req_valid && array_req_ready) begin
            fetch_addr_reg <= next_addr(fetch_addr_reg, words, wrap_eff);
            fetch_left_reg <= cont ? fetch_left_reg : fetch_left_reg - 5'h01;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            pend_reg <= 1'b0;
        else if (array_req_valid && array_req_ready)
            pend_reg <= 1'b1;
        else if (array_rsp_valid && array_rsp_ready)
            pend_reg <= 1'b0;
    end

    always_ff @(posedge clk) begin
        if (push)
            mem[wr_ptr_reg] <= array_rsp_data;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_reg  <= '0;
            rd_ptr_reg  <= '0;
            buf_cnt_reg <= '0;
        end else if (start || state_reg == ST_IDLE) begin
            wr_ptr_reg  <= '0;
            rd_ptr_reg  <= '0;
            buf_cnt_reg <= '0;
        end else begin
            wr_ptr_reg  <= push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
            rd_ptr_reg  <= pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
            buf_cnt_reg <= buf_cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // ****************************************************************
    // Output pins
    // ****************************************************************
    logic pred_bad, wait_act;

    // Early wait looks one data cycle ahead of the state
    always_comb begin
        case (state_reg)
            ST_LAT:  pred_bad = lat_cnt_reg > (hold2 ? 3'h2 : 3'h1);
            ST_DATA: pred_bad = (!cont && words_left_reg == 5'h00) || need_ws;
            ST_WAIT: pred_bad = (buf_cnt_reg == '0);
            ST_DONE: pred_bad = 1'b1;
            default: pred_bad = 1'b0;
        endcase
    end

    assign wait_act = sync_mode && state_reg != ST_IDLE
                      && (cfg_reg.wait_timing_sel ? pred_bad : state_reg != ST_DATA);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wait_out <= 1'b0;
            wait_oe  <= 1'b0;
            dq_oe    <= 1'b0;
        end else begin
            wait_out <= cfg_reg.wait_polarity_sel ? wait_act : !wait_act;
            wait_oe  <= ce_on && !pin.out_en_n;
            dq_oe    <= ce_on && !pin.out_en_n && sync_mode && state_reg != ST_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            dq_out <= '0;
        else if (pop)
            dq_out <= mem[rd_ptr_reg];
    end

    assign burst_active = (state_reg != ST_IDLE);

endmodule // burst_read_config_sequencer

/* File: tb/burst_seq_monitor.sv */
// Port checks for the burst read sequencer.
// Assumes one clk domain and pins far slower than clk.
`timescale 1ns/1ps
module burst_seq_monitor
    import burst_cfg_pkg::*;
#(
    parameter int ADDR_W = 23,
    parameter int DATA_W = 16
) (
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic              cfg_load,
    input wire cfg_t              cfg_value,
    input wire cfg_t              cfg_readback,
    input wire logic              array_req_valid,
    input wire logic              array_req_ready,
    input wire logic [ADDR_W-1:0] array_req_addr,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic              dq_oe,
    input wire logic              wait_out,
    input wire logic              burst_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // ********
    // Checks
    // ********
    chk_cfg_load: assert property (cfg_load |=> cfg_readback == $past(cfg_value))
        else $error("config readback differs from loaded word");
    chk_async_wait: assert property ((cfg_readback.read_sync_select && $stable(cfg_readback))
        |=> wait_out == !$past(cfg_readback.wait_polarity_sel)) else $error("wait active in async mode");
    chk_async_idle: assert property (cfg_readback.read_sync_select && $past(cfg_readback.read_sync_select)
        |-> !burst_active) else $error("burst running in async mode");
    chk_oe_sync: assert property (dq_oe |-> !cfg_readback.read_sync_select)
        else $error("data driven in async mode");
    chk_wait_start: assert property ($rose(burst_active) && !cfg_readback.wait_timing_sel
        |-> ##[0:1] wait_out == cfg_readback.wait_polarity_sel) else $error("no wait during latency");
    // Hold two: sixteen clk per word at the bench rate, eight is safe
    chk_hold_two: assert property ($changed(dq_out) && dq_oe && cfg_readback.data_hold_sel
        |=> $stable(dq_out) [*8]) else $error("word not held two clocks");
    chk_hold_one: assert property ($changed(dq_out) && dq_oe && !cfg_readback.data_hold_sel
        |=> $stable(dq_out) [*5]) else $error("word not held one clock");
    chk_req_hold: assert property (array_req_valid && !array_req_ready && burst_active
        |=> !burst_active || (array_req_valid && $stable(array_req_addr))) else $error("request dropped");
    chk_one_req: assert property (array_req_valid && array_req_ready |=> !array_req_valid)
        else $error("second request outstanding");
    cov_burst: cover property ($rose(burst_active));
    cov_loads: cover property (cfg_load ##1 cfg_load);
    cov_wait_data: cover property (dq_oe && wait_out == cfg_readback.wait_polarity_sel);
endmodule // burst_seq_monitor

bind burst_read_config_sequencer burst_seq_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_burst_seq_monitor (
    .clk(clk), .rstn(rstn), .cfg_load(cfg_load), .cfg_value(cfg_value), .cfg_readback(cfg_readback),
    .array_req_valid(array_req_valid), .array_req_ready(array_req_ready), .array_req_addr(array_req_addr),
    .dq_out(dq_out), .dq_oe(dq_oe), .wait_out(wait_out), .burst_active(burst_active));

/* File: tb/burst_host_model.sv */
// Host controller model driving the burst read pins.
// Assumes the bench calls frame(); burst clock stands still between frames.
`timescale 1ns/1ps
module burst_host_model #(
    parameter int ADDR_W = 23
) (
    output logic              burst_clk,
    output logic              latch_n,
    output logic              chip_en_n,
    output logic              out_en_n,
    output logic [ADDR_W-1:0] addr_pin
);
    int   edge_cnt = 0;
    logic busy     = 1'b0;
    initial begin
        burst_clk = 1'b0;
        latch_n = 1'b1;
        chip_en_n = 1'b1;
        out_en_n = 1'b1;
        addr_pin = '0;
    end
    task automatic frame(logic [ADDR_W-1:0] a, logic rising, int n);
        #7;
        busy = 1'b1;
        edge_cnt = 0;
        addr_pin = a;
        latch_n = 1'b0;
        chip_en_n = 1'b0;
        out_en_n = 1'b0;
        #300;
        repeat (n) begin
            #200 burst_clk = 1'b1;
            if (rising) edge_cnt++;
            #200 burst_clk = 1'b0;
            if (!rising) edge_cnt++;
        end
        #1000;
        busy = 1'b0;
        chip_en_n = 1'b1;
        out_en_n = 1'b1;
        latch_n = 1'b1;
        // Released pins show no stale address
        addr_pin = ~a;
    endtask
endmodule // burst_host_model

/* File: tb/burst_read_config_sequencer_tb.sv */
// Self-checking bench for the burst read sequencer.
// Assumes package, core, host model and monitor compiled before it.
`timescale 1ns/1ps
module burst_read_config_sequencer_tb;
    import burst_cfg_pkg::*;
    localparam int AW = 23;
    logic          clk = 1'b0, rstn = 1'b0, cfg_load = 1'b0;
    cfg_t          cfg_value = CFG_RESET, cfg_readback, c = CFG_RESET;
    logic          burst_clk, latch_n, chip_en_n, out_en_n, dq_oe, wait_out, wait_oe, burst_active;
    logic [AW-1:0] addr_pin, array_req_addr, rsp_addr = '0;
    logic          array_req_valid, array_rsp_ready, array_req_ready = 1'b0, array_rsp_valid = 1'b0;
    logic [15:0]   array_rsp_data = 16'h0000, dq_out, last_dq;
    logic [AW-1:0] fetched[$];
    logic [15:0]   shown[$];
    logic          prev_act = 1'b0;
    int            mismatches = 0, n_compared = 0, rsp_wait = 0, first_edge = 0, wait_rises = 0, cycles = 0;

    always #25 clk = ~clk;

    burst_host_model #(.ADDR_W(AW)) i_host (.burst_clk(burst_clk), .latch_n(latch_n), .chip_en_n(chip_en_n),
        .out_en_n(out_en_n), .addr_pin(addr_pin));
    burst_read_config_sequencer #(.ADDR_W(AW)) i_burst_read_config_sequencer (.clk(clk), .rstn(rstn),
        .burst_clk(burst_clk), .latch_n(latch_n), .chip_en_n(chip_en_n), .out_en_n(out_en_n), .addr_pin(addr_pin),
        .cfg_load(cfg_load), .cfg_value(cfg_value), .cfg_readback(cfg_readback), .array_req_valid(array_req_valid),
        .array_req_ready(array_req_ready), .array_req_addr(array_req_addr), .array_rsp_valid(array_rsp_valid),
        .array_rsp_ready(array_rsp_ready), .array_rsp_data(array_rsp_data), .dq_out(dq_out), .dq_oe(dq_oe),
        .wait_out(wait_out), .wait_oe(wait_oe), .burst_active(burst_active));

    // ********
    // Expectations and compares
    // ********
    function automatic int words_of(logic [2:0] code);
        return (code == LEN_4) ? 4 : (code == LEN_8) ? 8 : (code == LEN_16) ? 16 : 0;
    endfunction
    function automatic logic [AW-1:0] exp_addr(logic [AW-1:0] s, int n, logic wrap, int i);
        logic [AW-1:0] m;
        m = AW'(n - 1);
        return (n != 0 && wrap) ? ((s & ~m) | ((s + AW'(i)) & m)) : s + AW'(i);
    endfunction
    function automatic logic [15:0] data_of(logic [AW-1:0] a);
        return a[15:0] ^ 16'h5A3C;
    endfunction
    // Fixed bursts add one rise at their end; misaligned starts add one at the sixteen word crossing
    function automatic int exp_waits(logic [AW-1:0] s, int n, logic nowrap);
        int ws;
        ws = (s[2:0] != 3'h0 && (n == 0 || (nowrap && int'(s[3:0]) + n > 16))) ? 1 : 0;
        return ws + ((n != 0) ? 1 : 0);
    endfunction
    task automatic fail(string m);
        mismatches++;
        $display("CHECK FAILED %0t %s", $time, m);
    endtask
    task automatic check_word(logic [15:0] g, logic [15:0] e, string m);
        n_compared++;
        if (g !== e) fail(m);
    endtask
    task automatic check_addr(logic [AW-1:0] g, logic [AW-1:0] e, string m);
        n_compared++;
        if (g !== e) fail(m);
    endtask
    task automatic check_count(int g, int e, string m);
        n_compared++;
        if (g != e) fail(m);
    endtask
    task automatic check_bit(logic g, logic e, string m);
        n_compared++;
        if (g !== e) fail(m);
    endtask
    task automatic test_done();
        if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic load_cfg(cfg_t v);
        @(posedge clk);
        cfg_load <= 1'b1;
        cfg_value <= v;
        @(posedge clk);
        cfg_load <= 1'b0;
        @(posedge clk);
        #1;
        check_word(cfg_readback, v, "config readback");
    endtask
    task automatic run_burst(logic [AW-1:0] s, int edges);
        fetched.delete();
        shown.delete();
        last_dq = dq_out;
        wait_rises = 0;
        fork
            i_host.frame(s, c.active_edge_sel, edges);
            begin
                #1000;
                check_bit(wait_oe, 1'b1, "wait pin not driven in frame");
            end
        join
        #1000;
        check_bit(wait_oe, 1'b0, "wait pin driven after frame");
    endtask

    // ********
    // Array model, observers, watchdog
    // ********
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fail("timeout");
            test_done();
        end
        array_req_ready <= ($urandom_range(0, 3) != 0);
        if (array_rsp_valid && array_rsp_ready) begin
            array_rsp_valid <= 1'b0;
            array_rsp_data <= ~array_rsp_data;
        end
        if (array_req_valid && array_req_ready) begin
            fetched.push_back(array_req_addr);
            rsp_addr <= array_req_addr;
            rsp_wait <= $urandom_range(1, 3);
        end else if (rsp_wait == 1) begin
            array_rsp_valid <= 1'b1;
            array_rsp_data <= data_of(rsp_addr);
            rsp_wait <= 0;
        end else if (rsp_wait > 1) rsp_wait <= rsp_wait - 1;
        if (dq_oe && burst_active && dq_out !== last_dq) begin
            if (shown.size() == 0) first_edge <= i_host.edge_cnt;
            shown.push_back(dq_out);
            last_dq <= dq_out;
        end
        prev_act <= (wait_out === c.wait_polarity_sel);
        if (shown.size() > 0 && i_host.busy && wait_out === c.wait_polarity_sel && !prev_act) wait_rises++;
    end

    // ********
    // Main sequence
    // ********
    initial begin
        logic [AW-1:0] s;
        int            n, k, lat;
        static logic [3:0] lows[8] = '{4'h0, 4'h1, 4'h7, 4'h8, 4'hC, 4'hF, 4'h3, 4'hE};
        static logic [2:0] lens[4] = '{LEN_4, LEN_8, LEN_16, 3'h7};
        void'($urandom(32'h2FCF02E1));
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        check_word(cfg_readback, CFG_RESET, "reset config");
        run_burst(23'h000005, 6);
        check_count(fetched.size() + shown.size(), 0, "burst in async mode");
        for (int i = 0; i < 14; i++) begin
            lat = (i == 13) ? 7 : $urandom_range(2, 7);
            c = cfg_t'(16'($urandom));
            c.read_sync_select = 1'b0;
            c.reserved_hi = 1'b1;
            c.reserved_mid_a = 1'b0;
            c.reserved_mid_b = 1'b0;
            c.first_access_latency = (i == 13) ? 3'h1 : 3'(lat);
            c.burst_len_sel = (i == 12) ? 3'h5 : lens[i % 4];
            c.burst_order_sel = (i != 1);
            if (lat == 2 && c.data_hold_sel && c.wait_timing_sel) c.wait_timing_sel = 1'b0;
            s = AW'($urandom);
            if (i < 8) s[3:0] = lows[i];
            load_cfg(c);
            n = words_of(c.burst_len_sel);
            k = (n == 0) ? 20 : n;
            run_burst(s, lat + 3 + (c.data_hold_sel ? 2 : 1) * (k + 2));
            check_count(first_edge, lat + 1, "first word latency");
            for (int j = 0; j < k; j++) begin
                check_addr(fetched[j], exp_addr(s, n, !c.wrap_disable, j), "burst address");
                check_word(shown[j], data_of(exp_addr(s, n, !c.wrap_disable, j)), "burst word");
            end
            if (n != 0) check_count(shown.size(), n, "burst length");
            check_count(wait_rises, exp_waits(s, n, c.wrap_disable), "wait states");
        end
        test_done();
    end
endmodule // burst_read_config_sequencer_tb
